//--- logic/polarity_pkg.sv
// Constants shared by the polarity-correction block
package polarity_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] status_addr = 12'h004;
  localparam logic [11:0] idle_addr = 12'h008;
  localparam int ctrl_rx_en_n_bit = 0;
  localparam int ctrl_drv_en_bit = 1;
  localparam logic [1:0] ctrl_reset = 2'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int clk_mhz = 25;
  localparam int failsafe_min_ms = 44;
  localparam int failsafe_max_ms = 76;
  localparam int standby_ns = 300;
  localparam int clk_period_ns = 40;
  localparam int failsafe_min_cycles = failsafe_min_ms * 1000 * clk_mhz;
  localparam int failsafe_max_cycles = failsafe_max_ms * 1000 * clk_mhz;
  localparam int standby_cycles = (standby_ns + clk_period_ns - 1) / clk_period_ns;

  // ****************************************
  // Detector states
  // ****************************************
  typedef enum logic [1:0] {
    st_watch = 2'b00,
    st_locked = 2'b01
  } detect_state_t;

endpackage : polarity_pkg

//--- logic/word_buffer.sv
// Two-entry valid/ready buffer for received bus samples
`timescale 1ns/100ps
module word_buffer #(
  parameter int width = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  logic [width-1:0] mem [2];
  logic [width-1:0] next_mem [2];
  logic [1:0] count;
  logic [1:0] next_count;
  logic rd_ptr;
  logic next_rd_ptr;
  logic wr_ptr;
  logic next_wr_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_mem = mem;
    next_count = count;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem[0] <= '0;
      mem[1] <= '0;
      count <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      mem <= next_mem;
      count <= next_count;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
    end
  end

  chk_no_overfill: assert property (@(posedge pclk) disable iff (!presetn)
    count <= 2'h2) else $error("Buffer count above two");
endmodule : word_buffer

//--- logic/polarity_fix_logic.sv
// Bus polarity detection, correction and enable control
// Operation
// - Detect polarity only while receiver enabled and driver disabled.
// - Decide polarity after the bus idles for the failsafe interval.
// - Apply one inversion setting to both receive and transmit paths.
// - Latch detected polarity and keep it for all later traffic.
// - Inversion starts cleared after power-up.
// - Low idle level after failsafe interval sets inversion.
// - Detection repeats on every power-up, old polarity discarded.
// - Standby only when driver and receiver both disabled.
// - With receiver enabled, own transmitted bus data comes back.
// - A correctly biased idle bus gives a high receiver output.
// - Standby only after both enables disabled for 300 ns.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
module polarity_fix_logic #(
  parameter int failsafe_cycles = polarity_pkg::failsafe_min_cycles
    + (polarity_pkg::failsafe_max_cycles - polarity_pkg::failsafe_min_cycles) / 2,
  parameter int standby_cycles = polarity_pkg::standby_cycles
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller side
  input wire logic tx_data,
  output logic rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // Line side
  input wire logic bus_level,
  output logic line_drive,
  output logic line_drive_en,
  output logic standby
);
  initial begin
    if (failsafe_cycles < 1 || standby_cycles < 1) begin
      $error("Timing counts must be at least one cycle");
    end
  end

  // ****************************************
  // Input synchroniser and registers
  // ****************************************
  logic [2:0] sync;
  logic bus_stable;
  logic next_bus_stable;
  logic receiver_enable_n;
  logic driver_enable;
  logic next_receiver_enable_n;
  logic next_driver_enable;
  logic apb_access;

  assign apb_access = psel && penable;
  assign pready = 1'b1;

  // Change the level only when the last two stages agree
  always_comb begin
    next_bus_stable = bus_stable;
    if (sync[1] == sync[2]) begin
      next_bus_stable = sync[2];
    end
  end

  always_comb begin
    next_receiver_enable_n = receiver_enable_n;
    next_driver_enable = driver_enable;
    if (apb_access && pwrite && paddr == polarity_pkg::ctrl_addr) begin
      next_receiver_enable_n = pwdata[polarity_pkg::ctrl_rx_en_n_bit];
      next_driver_enable = pwdata[polarity_pkg::ctrl_drv_en_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync <= 3'h7;
      bus_stable <= 1'b1;
      receiver_enable_n <= polarity_pkg::ctrl_reset[polarity_pkg::ctrl_rx_en_n_bit];
      driver_enable <= polarity_pkg::ctrl_reset[polarity_pkg::ctrl_drv_en_bit];
    end else begin
      sync <= {sync[1:0], bus_level};
      bus_stable <= next_bus_stable;
      receiver_enable_n <= next_receiver_enable_n;
      driver_enable <= next_driver_enable;
    end
  end

  // ****************************************
  // Polarity detector
  // ****************************************
  polarity_pkg::detect_state_t state;
  polarity_pkg::detect_state_t next_state;
  logic invert;
  logic next_invert;
  logic [31:0] idle_count;
  logic [31:0] next_idle_count;
  logic prev_level;
  logic next_prev_level;
  logic listening;

  // Receiver on, driver off: the only safe time to judge the bus
  assign listening = !receiver_enable_n && !driver_enable;

  always_comb begin
    next_state = state;
    next_invert = invert;
    next_idle_count = idle_count;
    next_prev_level = bus_stable;
    case (state)
      polarity_pkg::st_watch: begin
        if (!listening || bus_stable != prev_level) begin
          next_idle_count = 32'h0;
        end else if (idle_count >= 32'(failsafe_cycles - 1)) begin
          next_invert = !bus_stable;
          next_state = polarity_pkg::st_locked;
        end else begin
          next_idle_count = idle_count + 32'h1;
        end
      end
      polarity_pkg::st_locked: begin
        // Never re-evaluated during traffic; long runs would fool it
        next_state = polarity_pkg::st_locked;
      end
      default: begin
        next_state = polarity_pkg::st_watch;
      end
    endcase
  end

  // Reset is power-up: everything restarts uncorrected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= polarity_pkg::st_watch;
      invert <= 1'b0;
      idle_count <= 32'h0;
      prev_level <= 1'b1;
    end else begin
      state <= next_state;
      invert <= next_invert;
      idle_count <= next_idle_count;
      prev_level <= next_prev_level;
    end
  end

  // ****************************************
  // Data paths and standby
  // ****************************************
  logic rx_corrected;
  logic buf_in_ready;
  logic next_line_drive;
  logic next_line_drive_en;
  logic [31:0] off_count;
  logic [31:0] next_off_count;
  logic next_standby;

  // Idle high bias passes through as high once corrected
  assign rx_corrected = bus_stable ^ invert;

  word_buffer #(
    .width(1)
  ) rx_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(!receiver_enable_n),
    .in_ready(buf_in_ready),
    .in_data(rx_corrected),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  always_comb begin
    next_line_drive = tx_data ^ invert;
    next_line_drive_en = driver_enable;
    next_off_count = 32'h0;
    next_standby = 1'b0;
    if (receiver_enable_n && !driver_enable) begin
      next_off_count = off_count;
      if (off_count < 32'(standby_cycles)) begin
        next_off_count = off_count + 32'h1;
      end
      next_standby = (next_off_count >= 32'(standby_cycles));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_drive <= 1'b0;
      line_drive_en <= 1'b0;
      off_count <= 32'h0;
      standby <= 1'b0;
    end else begin
      line_drive <= next_line_drive;
      line_drive_en <= next_line_drive_en;
      off_count <= next_off_count;
      standby <= next_standby;
    end
  end

  // ****************************************
  // APB read
  // ****************************************
  always_comb begin
    prdata = 32'h0;
    pslverr = 1'b0;
    if (paddr == polarity_pkg::ctrl_addr) begin
      prdata = {30'h0, driver_enable, receiver_enable_n};
    end else if (paddr == polarity_pkg::status_addr) begin
      prdata = {28'h0, standby, !buf_in_ready, state == polarity_pkg::st_locked, invert};
    end else if (paddr == polarity_pkg::idle_addr) begin
      prdata = idle_count;
    end else begin
      pslverr = apb_access;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_invert_held: assert property (@(posedge pclk) disable iff (!presetn)
    state == polarity_pkg::st_locked |=> $stable(invert)) else $error("Invert changed after lock");
  chk_lock_needs_listen: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == polarity_pkg::st_locked) |-> $past(listening)) else $error("Locked while not listening");
  chk_lock_on_idle: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == polarity_pkg::st_locked) |-> invert == !$past(bus_stable)) else $error("Wrong polarity");
  chk_idle_restart: assert property (@(posedge pclk) disable iff (!presetn)
    state == polarity_pkg::st_watch && bus_stable != prev_level |=> idle_count == 32'h0)
    else $error("Idle timer not restarted");
  chk_lock_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == polarity_pkg::st_locked) |-> $past(idle_count) == 32'(failsafe_cycles - 1))
    else $error("Lock before failsafe interval");
  chk_tx_path: assert property (@(posedge pclk) disable iff (!presetn)
    line_drive == ($past(tx_data) ^ $past(invert))) else $error("Transmit inversion wrong");
  // A level change must come from two agreeing synchroniser stages
  chk_sync_agree: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(bus_stable) |-> $past(sync[1] == sync[2]))
    else $error("Line level taken before stages agreed");
  chk_standby_late: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(standby) |-> $past(receiver_enable_n) && !$past(driver_enable)
    && off_count == 32'(standby_cycles)) else $error("Standby too early");
  chk_standby_both: assert property (@(posedge pclk) disable iff (!presetn)
    standby |-> $past(receiver_enable_n) && !$past(driver_enable)) else $error("Standby while enabled");
  chk_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
    state == polarity_pkg::st_watch |-> !invert) else $error("Invert set before decision");

  // ****************************************
  // Checks on counters and enables
  // ****************************************
  chk_line_enable: assert property (@(posedge pclk) disable iff (!presetn)
    line_drive_en == $past(driver_enable))
    else $error("Driver enable not passed to line");
  chk_standby_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (!receiver_enable_n || driver_enable) |=> !standby)
    else $error("Standby held while enabled");
  chk_standby_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(standby) |-> $past(off_count) == 32'(standby_cycles - 1))
    else $error("Standby after wrong disabled time");
  chk_standby_full: assert property (@(posedge pclk) disable iff (!presetn)
    standby |-> off_count == 32'(standby_cycles))
    else $error("Standby without full disabled time");
  chk_off_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (!receiver_enable_n || driver_enable) |=> off_count == 32'h0)
    else $error("Disabled timer not cleared");
  // Leaving the listening state must throw away partial idle time
  chk_idle_leave: assert property (@(posedge pclk) disable iff (!presetn)
    state == polarity_pkg::st_watch && !listening |=> idle_count == 32'h0)
    else $error("Idle timer kept while not listening");
  chk_idle_bound: assert property (@(posedge pclk) disable iff (!presetn)
    idle_count < 32'(failsafe_cycles))
    else $error("Idle timer past failsafe interval");
  chk_idle_step: assert property (@(posedge pclk) disable iff (!presetn)
    state == polarity_pkg::st_watch && listening && bus_stable == prev_level
    && idle_count < 32'(failsafe_cycles - 1) |=> idle_count == $past(idle_count) + 32'h1)
    else $error("Idle timer did not advance");
  chk_lock_stays: assert property (@(posedge pclk) disable iff (!presetn)
    state == polarity_pkg::st_locked |=> state == polarity_pkg::st_locked)
    else $error("Lock lost during traffic");
  chk_lock_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    state == polarity_pkg::st_locked |=> $stable(idle_count))
    else $error("Idle timer moved after lock");
  chk_lock_from_watch: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == polarity_pkg::st_locked) |-> $past(state) == polarity_pkg::st_watch)
    else $error("Lock without a watch phase");
  // Software writes are the only way the enables move
  chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    apb_access && pwrite && paddr == polarity_pkg::ctrl_addr
    |=> receiver_enable_n == $past(pwdata[polarity_pkg::ctrl_rx_en_n_bit]))
    else $error("Receiver enable write lost");
  chk_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(apb_access && pwrite && paddr == polarity_pkg::ctrl_addr)
    |=> $stable(receiver_enable_n) && $stable(driver_enable))
    else $error("Enables moved without a write");
endmodule : polarity_fix_logic

//--- tb/remote_node.sv
// Far-end bus node model driving the line level seen by the block
`timescale 1ns/100ps
module remote_node (
  // Clock
  input wire logic pclk,
  // Far node control
  input wire logic crossed,
  input wire logic sending,
  input wire logic send_bit,
  // Local driver
  input wire logic line_drive,
  input wire logic line_drive_en,
  // Line
  output logic bus_level
);
  logic far_level = 1'b1;
  // ****************************************
  // Idle bias high at the master
  // ****************************************
  always @(posedge pclk) begin
    far_level <= sending ? send_bit : 1'b1;
  end
  // Own driver seen directly, far node through the crossed pair
  assign bus_level = line_drive_en ? line_drive : (far_level ^ crossed);
endmodule : remote_node

//--- tb/test_bus_polarity_correction.sv
// Self-checking bench for the polarity-correction block
`timescale 1ns/100ps
module test_bus_polarity_correction;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, tx_data = 0, rx_data, rx_valid, rx_ready = 1;
  logic bus_level, line_drive, line_drive_en, standby;
  logic crossed = 1, sending = 0, send_bit = 0;
  int mismatches = 0, comparisons = 0, cycles = 0, n, exp_inv;
  logic [1:0] n_dir [2] = '{2'h3, 2'h0};
  always #20 pclk = ~pclk;
  polarity_fix_logic #(.failsafe_cycles(50), .standby_cycles(8)) u_polarity_fix_logic (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .bus_level(bus_level), .line_drive(line_drive),
    .line_drive_en(line_drive_en), .standby(standby));
  remote_node u_remote_node (.pclk(pclk), .crossed(crossed), .sending(sending), .send_bit(send_bit),
    .line_drive(line_drive), .line_drive_en(line_drive_en), .bus_level(bus_level));
  // ****************************************
  // Shared tasks
  // ****************************************
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task wait_neg(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask : wait_neg
  // Cuts a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(30529));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    wait_neg(12); check(standby, 1);
    apb(0, polarity_pkg::ctrl_addr, 0); check(rd, 32'h1);
    apb(0, polarity_pkg::status_addr, 0); check(rd, 32'h8);
    apb(1, 12'h00C, 32'hF); check(err, 1);
    apb(0, 12'h00C, 0); check(err, 1); check(rd, 0);
    apb(1, polarity_pkg::ctrl_addr, 0); wait_neg(3); check(standby, 0);
    wait_neg(30); check(rx_data, 0);
    @(posedge pclk); crossed <= 0; repeat (4) @(posedge pclk); crossed <= 1;
    // Let the short glitch drain, then count cycles from its end
    wait_neg(11); n = 12;
    while (rx_data !== 1'b1 && n < 300) begin
      wait_neg(0); n++;
    end
    exp_inv = 1;
    check(n >= 50 && n <= 60, 1);
    apb(0, polarity_pkg::status_addr, 0); check(rd, 32'h3);
    crossed <= 0; wait_neg(80); check(rx_data, 1 ^ exp_inv);
    // Random traffic with short runs, then a stalled receiver
    sending <= 1;
    repeat (40) begin
      @(posedge pclk); send_bit <= ~send_bit ^ ($urandom % 2 == 0); rx_ready <= 1'($urandom);
    end
    sending <= 0; rx_ready <= 0; wait_neg(10); check(rx_valid, 1);
    apb(0, polarity_pkg::status_addr, 0); check(rd[2:0], 3'h7);
    rx_ready <= 1; wait_neg(10); check(rx_data, 1 ^ exp_inv);
    // Transmit path and echo of own data
    apb(1, polarity_pkg::ctrl_addr, 2);
    repeat (8) begin
      @(posedge pclk); tx_data <= 1'($urandom);
      wait_neg(2); check({line_drive_en, line_drive}, {1'b1, tx_data ^ exp_inv[0]});
      wait_neg(8); check(rx_data, tx_data);
    end
    foreach (n_dir[i]) begin
      apb(1, polarity_pkg::ctrl_addr, n_dir[i]); wait_neg(2); check(line_drive_en, n_dir[i] >> 1);
    end
    // Brief disable pulse, then a held one
    apb(1, polarity_pkg::ctrl_addr, 1); apb(1, polarity_pkg::ctrl_addr, 0);
    wait_neg(10); check(standby, 0);
    apb(1, polarity_pkg::ctrl_addr, 1); wait_neg(4); check(standby, 0);
    wait_neg(8); check(standby, 1);
    // Second power-up on a correctly wired bus
    presetn <= 0; repeat (2) @(posedge pclk); presetn <= 1;
    exp_inv = 0;
    apb(0, polarity_pkg::status_addr, 0); check(rd, 32'h0);
    apb(1, polarity_pkg::ctrl_addr, 0); wait_neg(120);
    apb(0, polarity_pkg::status_addr, 0); check(rd, 32'h2);
    check(rx_data, 1 ^ exp_inv);
    results();
  end
endmodule : test_bus_polarity_correction
